// ### hw/imu_core_pkg.sv
package imu_core_pkg;
  // ----------------------------------------
  // data carriers
  // ----------------------------------------
  typedef logic signed [15:0] word_type;
  typedef word_type [2:0] vec_type;
  typedef vec_type [2:0] mat_type;
  typedef struct packed {
    vec_type gyro;
    vec_type accel;
  } sample_type;
  localparam int CHANNELS = 6;

  // ----------------------------------------
  // link frame layout
  // ----------------------------------------
  localparam logic [3:0] FRAME_LAST = 4'hF;
  localparam int WR_BIT = 15;
  localparam int ADDR_MSB = 14;
  localparam int ADDR_LSB = 8;

  // ----------------------------------------
  // control fields and clock modes
  // ----------------------------------------
  localparam int MISC_POL_BIT = 0;
  localparam int MISC_MODE_LSB = 2;
  localparam int MISC_MODE_MSB = 4;
  localparam int MISC_PP_BIT = 6;
  localparam int MISC_LG_BIT = 7;
  localparam logic [2:0] MODE_INTERNAL = 3'h0;
  localparam logic [2:0] MODE_SCALED = 3'h2;
  localparam logic [2:0] FIR_MAX_SHIFT = 3'h5;
  localparam int FIR_DEPTH = 32;

  // ----------------------------------------
  // byte addresses and reset values
  // ----------------------------------------
  localparam logic [6:0] ADDR_GYRO_X = 7'h06;
  localparam logic [6:0] ADDR_GYRO_Y = 7'h0A;
  localparam logic [6:0] ADDR_GYRO_Z = 7'h0E;
  localparam logic [6:0] ADDR_ACC_X = 7'h12;
  localparam logic [6:0] ADDR_ACC_Y = 7'h16;
  localparam logic [6:0] ADDR_ACC_Z = 7'h1A;
  localparam logic [6:0] ADDR_COUNT = 7'h22;
  localparam logic [6:0] ADDR_FIR = 7'h5C;
  localparam logic [6:0] ADDR_MISC = 7'h60;
  localparam logic [6:0] ADDR_DEC = 7'h64;
  localparam logic [15:0] MISC_RST = 16'h00C1;
  localparam logic [15:0] FIR_RST = 16'h0000;
  localparam logic [15:0] DEC_RST = 16'h0000;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_RATE_SPS = 2000;
  localparam int TICK_CYC = 1000000000 / (CLK_PERIOD_NS * SAMPLE_RATE_SPS);
  localparam int DR_HOLD_NS = 1000;
  localparam logic [5:0] DR_HOLD_CYC =
    6'((DR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  // ----------------------------------------
  // factory correction factors, q2.14
  // ----------------------------------------
  localparam int COEF_FRAC = 14;
  localparam mat_type GYRO_SCALE = '{'{16'h4000, 16'h0000, 16'h0000},
                                     '{16'h0000, 16'h4000, 16'h0000},
                                     '{16'h0000, 16'h0000, 16'h4000}};
  localparam vec_type GYRO_BIAS = '{16'h0000, 16'h0000, 16'h0000};
  localparam mat_type GYRO_LG = '{'{16'h0010, 16'h0000, 16'h0000},
                                  '{16'h0000, 16'h0010, 16'h0000},
                                  '{16'h0000, 16'h0000, 16'h0010}};
  localparam mat_type ACC_SCALE = '{'{16'h4000, 16'h0000, 16'h0000},
                                    '{16'h0000, 16'h4000, 16'h0000},
                                    '{16'h0000, 16'h0000, 16'h4000}};
  localparam vec_type ACC_BIAS = '{16'h0000, 16'h0000, 16'h0000};
  localparam mat_type ACC_PP = '{'{16'h0000, 16'h0008, 16'h0008},
                                 '{16'h0008, 16'h0000, 16'h0008},
                                 '{16'h0008, 16'h0008, 16'h0000}};
endpackage

// ### hw/spi_link.sv
`timescale 1ns/1ps
module spi_link
  import imu_core_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  output logic frame_valid,
  output logic [15:0] frame_word,
  input wire logic [15:0] reply_word
);
  logic [3:0] rx_cnt_q;
  logic [15:0] rx_sh_q;
  logic [15:0] rx_word_q;
  logic rx_tog_q;
  logic [3:0] tx_cnt_q;
  logic [15:0] tx_sh_q;
  logic miso_q;
  logic [2:0] tog_sync_q;
  logic valid_q;
  logic [15:0] word_q;
  wire [15:0] rx_next = {rx_sh_q[14:0], mosi};
  wire rx_last = rx_cnt_q == FRAME_LAST;
  wire tog_edge = tog_sync_q[2] ^ tog_sync_q[1];

  // ----------------------------------------
  // link side, capture at rising edge
  // ----------------------------------------
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 16'h0000;
    end else begin
      rx_cnt_q <= rx_cnt_q + 4'h1;
      rx_sh_q <= rx_next;
    end
  end

  always_ff @(posedge sclk or posedge rst) begin
    if (rst) begin
      rx_word_q <= 16'h0000;
      rx_tog_q <= 1'b0;
    end else if (!cs_n && rx_last) begin
      rx_word_q <= rx_next;
      rx_tog_q <= ~rx_tog_q;
    end
  end

  // ----------------------------------------
  // link side, launch at falling edge
  // ----------------------------------------
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      tx_cnt_q <= 4'h0;
      tx_sh_q <= 16'h0000;
      miso_q <= 1'b0;
    end else if (tx_cnt_q == 4'h0) begin
      tx_cnt_q <= 4'h1;
      tx_sh_q <= {reply_word[14:0], 1'b0};
      miso_q <= reply_word[15];
    end else begin
      tx_cnt_q <= tx_cnt_q + 4'h1;
      tx_sh_q <= {tx_sh_q[14:0], 1'b0};
      miso_q <= tx_sh_q[15];
    end
  end

  assign miso = miso_q;
  assign miso_oe = ~cs_n;

  // ----------------------------------------
  // frame event into the core clock
  // ----------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tog_sync_q <= 3'h0;
      valid_q <= 1'b0;
      word_q <= 16'h0000;
    end else begin
      tog_sync_q <= {tog_sync_q[1:0], rx_tog_q};
      valid_q <= tog_edge;
      if (tog_edge) begin
        word_q <= rx_word_q;
      end
    end
  end

  assign frame_valid = valid_q;
  assign frame_word = word_q;

  bit_step_a: assert property (@(negedge sclk) disable iff (cs_n)
    rx_cnt_q == tx_cnt_q)
    else $error("receive and send bit counts out of step");
  valid_once_a: assert property (@(posedge clk) disable iff (rst)
    frame_valid |=> !frame_valid)
    else $error("frame event lasted more than one cycle");
endmodule // spi_link

// ### hw/imu_core.sv
// Summary of operation
// - seven external clock modes, chosen by nonzero control bits 4..2, use sync input
// - control bit 7 enables gyro linear-g compensation
// - control bit 6 enables accel percussion-point alignment
// - correction factors are fixed constants, unreachable by register access
// - gyro = scale matrix times raw plus bias plus linear-g times accel
// - accel = matrix times raw plus bias plus terms of squared gyro
// - two cascaded averaging stages form the triangular fir filter
// - decimator averages a set number of samples per output update
// - each register has a low and a high byte at own addresses
// - host reads outputs and control registers, writes control registers only
// - link is a mode 3 serial slave, clock idles high
// - frames are sixteen bits, most significant bit first
// - internal mode processes data at 2000 per second, loads outputs once per decimation setting plus one samples
// - read frame: zero flag, seven bit address; data returns next frame
// - write frame: one flag, address, data byte; low byte then high
// - mode 010 is scaled sync; time stamp replaces the sample counter
`timescale 1ns/1ps
module imu_core
  import imu_core_pkg::*;
#(
  parameter int TICK_PERIOD = TICK_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe,
  input wire logic sync_in,
  input sample_type raw_sample,
  output logic sample_ready_output
);
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic vec_type mat_mul(input mat_type m, input vec_type v);
    logic signed [33:0] acc;
    vec_type res;
    for (int r = 0; r < 3; r++) begin
      acc = '0;
      for (int c = 0; c < 3; c++) begin
        acc = acc + 34'(m[r][c] * v[c]);
      end
      res[r] = acc[COEF_FRAC +: 16];
    end
    return res;
  endfunction

  function automatic vec_type vadd(input vec_type a, input vec_type b);
    vec_type res;
    for (int i = 0; i < 3; i++) begin
      res[i] = a[i] + b[i];
    end
    return res;
  endfunction

  // ----------------------------------------
  // serial link and register access
  // ----------------------------------------
  logic frame_valid;
  logic [15:0] frame_word;
  logic [15:0] tx_word_q;
  logic [15:0] misc_q;
  logic [15:0] fir_q;
  logic [15:0] dec_q;
  logic [7:0] stage_lo_q;
  logic [15:0] tag_q;
  word_type [CHANNELS-1:0] out_q;

  spi_link u_link (
    .clk(clk),
    .rst(rst),
    .sclk(sclk),
    .cs_n(cs_n),
    .mosi(mosi),
    .miso(miso),
    .miso_oe(miso_oe),
    .frame_valid(frame_valid),
    .frame_word(frame_word),
    .reply_word(tx_word_q)
  );

  function automatic logic [15:0] reg_read(input logic [6:0] a);
    logic [15:0] r;
    case ({a[6:1], 1'b0})
      ADDR_ACC_X: r = out_q[0];
      ADDR_ACC_Y: r = out_q[1];
      ADDR_ACC_Z: r = out_q[2];
      ADDR_GYRO_X: r = out_q[3];
      ADDR_GYRO_Y: r = out_q[4];
      ADDR_GYRO_Z: r = out_q[5];
      ADDR_COUNT: r = tag_q;
      ADDR_FIR: r = fir_q;
      ADDR_MISC: r = misc_q;
      ADDR_DEC: r = dec_q;
      default: r = 16'h0000;
    endcase
    return r;
  endfunction

  wire [6:0] fr_addr = frame_word[ADDR_MSB:ADDR_LSB];
  wire fr_wr = frame_word[WR_BIT];
  wire [7:0] fr_data = frame_word[7:0];
  wire wr_lo = frame_valid & fr_wr & ~fr_addr[0];
  wire wr_hi = frame_valid & fr_wr & fr_addr[0];
  wire [6:0] reg_base = {fr_addr[6:1], 1'b0};
  wire [15:0] commit = {fr_data, stage_lo_q};
  wire fir_clr = wr_hi & (reg_base == ADDR_FIR);
  wire dec_clr = fir_clr | (wr_hi & (reg_base == ADDR_DEC));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tx_word_q <= 16'h0000;
      stage_lo_q <= 8'h00;
      misc_q <= MISC_RST;
      fir_q <= FIR_RST;
      dec_q <= DEC_RST;
    end else begin
      if (frame_valid) begin
        tx_word_q <= fr_wr ? 16'h0000 : reg_read(fr_addr);
      end
      if (wr_lo) begin
        stage_lo_q <= fr_data;
      end
      if (wr_hi && reg_base == ADDR_MISC) begin
        misc_q <= commit;
      end
      if (fir_clr) begin
        fir_q <= commit;
      end
      if (wr_hi && reg_base == ADDR_DEC) begin
        dec_q <= commit;
      end
    end
  end

  // ----------------------------------------
  // processing rate
  // ----------------------------------------
  logic [2:0] sync_pipe_q;
  logic [14:0] tick_cnt_q;
  logic [15:0] ts_q;
  wire [2:0] mode = misc_q[MISC_MODE_MSB:MISC_MODE_LSB];
  wire mode_int = mode == MODE_INTERNAL;
  wire sync_rise = sync_pipe_q[1] & ~sync_pipe_q[2];
  wire tick_int = tick_cnt_q == 15'(TICK_PERIOD - 1);
  wire tick = mode_int ? tick_int : sync_rise;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sync_pipe_q <= 3'h0;
      tick_cnt_q <= 15'h0000;
      ts_q <= 16'h0000;
    end else begin
      sync_pipe_q <= {sync_pipe_q[1:0], sync_in};
      tick_cnt_q <= (tick_int | ~mode_int) ? 15'h0000 : tick_cnt_q + 15'h0001;
      ts_q <= ts_q + 16'h0001;
    end
  end

  // ----------------------------------------
  // factory calibration
  // ----------------------------------------
  sample_type cal_q;
  vec_type gyro_sq;
  wire vec_type gyro_base = vadd(mat_mul(GYRO_SCALE, raw_sample.gyro),
                                 GYRO_BIAS);
  wire vec_type acc_base = vadd(mat_mul(ACC_SCALE, raw_sample.accel),
                                ACC_BIAS);
  wire vec_type gyro_next = misc_q[MISC_LG_BIT] ?
    vadd(gyro_base, mat_mul(GYRO_LG, cal_q.accel)) : gyro_base;
  wire vec_type acc_next = misc_q[MISC_PP_BIT] ?
    vadd(acc_base, mat_mul(ACC_PP, gyro_sq)) : acc_base;

  genvar gi;
  for (gi = 0; gi < 3; gi++) begin : g_sq
    wire signed [31:0] prod = cal_q.gyro[gi] * cal_q.gyro[gi];
    assign gyro_sq[gi] = prod[COEF_FRAC +: 16];
  end

  logic [2:0] vld_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cal_q <= '0;
      vld_q <= 3'h0;
    end else begin
      vld_q <= {vld_q[1:0], tick};
      if (tick) begin
        cal_q <= {gyro_next, acc_next};
      end
    end
  end

  // ----------------------------------------
  // triangular fir, two boxcar stages
  // ----------------------------------------
  word_type [CHANNELS-1:0] fir_in [2];
  word_type [CHANNELS-1:0] fir_out [2];
  wire [2:0] fir_k = (fir_q[2:0] > FIR_MAX_SHIFT) ? FIR_MAX_SHIFT : fir_q[2:0];
  wire [4:0] fir_tail = 5'((6'h01 << fir_k) - 6'h01);
  assign fir_in[0] = cal_q;
  assign fir_in[1] = fir_out[0];
  genvar gs, gc;
  for (gs = 0; gs < 2; gs++) begin : g_stage
    for (gc = 0; gc < CHANNELS; gc++) begin : g_ch
      word_type hist [FIR_DEPTH];
      logic signed [20:0] sum_q;
      wire word_type x = fir_in[gs][gc];
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          sum_q <= '0;
          for (int i = 0; i < FIR_DEPTH; i++) begin
            hist[i] <= '0;
          end
        end else if (fir_clr) begin
          sum_q <= '0;
          for (int i = 0; i < FIR_DEPTH; i++) begin
            hist[i] <= '0;
          end
        end else if (vld_q[gs]) begin
          sum_q <= sum_q + 21'(x) - 21'(hist[fir_tail]);
          hist[0] <= x;
          for (int i = 1; i < FIR_DEPTH; i++) begin
            hist[i] <= hist[i-1];
          end
        end
      end
      assign fir_out[gs][gc] = sum_q[fir_k +: 16];
    end
  end

  // ----------------------------------------
  // decimating average and output load
  // ----------------------------------------
  logic [10:0] dec_cnt_q;
  logic [5:0] dr_cnt_q;
  logic [15:0] count_q;
  wire [10:0] dec_last = dec_q[10:0];
  wire out_load = vld_q[2] & (dec_cnt_q == dec_last);
  wire signed [27:0] dec_div = 28'({1'b0, dec_last}) + 28'sh0000001;
  word_type [CHANNELS-1:0] dec_avg;

  for (gc = 0; gc < CHANNELS; gc++) begin : g_dec
    logic signed [27:0] acc_q;
    wire signed [27:0] total = acc_q + 28'(fir_out[1][gc]);
    wire signed [27:0] quot = total / dec_div;
    assign dec_avg[gc] = quot[15:0];
    always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
        acc_q <= '0;
      end else if (dec_clr) begin
        acc_q <= '0;
      end else if (vld_q[2]) begin
        acc_q <= out_load ? 28'sh0000000 : total;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dec_cnt_q <= 11'h000;
      out_q <= '0;
      count_q <= 16'h0000;
      tag_q <= 16'h0000;
      dr_cnt_q <= 6'h00;
    end else begin
      if (vld_q[2] | dec_clr) begin
        dec_cnt_q <= (out_load | dec_clr) ? 11'h000 : dec_cnt_q + 11'h001;
      end
      if (out_load) begin
        out_q <= dec_avg;
        count_q <= count_q + 16'h0001;
        tag_q <= (mode == MODE_SCALED) ? ts_q : count_q + 16'h0001;
        dr_cnt_q <= DR_HOLD_CYC;
      end else if (dr_cnt_q != 6'h00) begin
        dr_cnt_q <= dr_cnt_q - 6'h01;
      end
    end
  end

  wire dr_active = dr_cnt_q != 6'h00;
  assign sample_ready_output = misc_q[MISC_POL_BIT] ? dr_active : ~dr_active;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic [14:0] since_q;
  logic seen_q;
  logic [11:0] dec_seen_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      since_q <= 15'h0000;
      seen_q <= 1'b0;
      dec_seen_q <= 12'h000;
    end else begin
      since_q <= tick ? 15'h0000 : since_q + 15'h0001;
      seen_q <= mode_int & (seen_q | tick);
      if (out_load | dec_clr) begin
        dec_seen_q <= 12'h000;
      end else if (vld_q[2]) begin
        dec_seen_q <= dec_seen_q + 12'h001;
      end
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence fir_walk_s;
    vld_q[0] ##1 vld_q[1] ##1 vld_q[2];
  endsequence

  int_rate_a: assert property (tick && mode_int && seen_q
    |-> since_q == 15'(TICK_PERIOD - 1))
    else $error("internal sample period wrong");
  ext_mode_a: assert property (!mode_int && $rose(sync_pipe_q[2])
    |-> $past(tick))
    else $error("sync edge did not start a sample");
  lg_off_a: assert property (tick && !misc_q[MISC_LG_BIT]
    |=> cal_q.gyro == $past(gyro_base))
    else $error("linear-g term applied while disabled");
  pp_off_a: assert property (tick && !misc_q[MISC_PP_BIT]
    |=> cal_q.accel == $past(acc_base))
    else $error("percussion term applied while disabled");
  gyro_form_a: assert property (tick && misc_q[MISC_LG_BIT]
    |=> cal_q.gyro == vadd($past(gyro_base),
                           mat_mul(GYRO_LG, $past(cal_q.accel))))
    else $error("gyro correction mismatch");
  fir_pipe_a: assert property (tick && !fir_clr
    |=> fir_walk_s)
    else $error("filter stages out of step");
  decimation_setting_a: assert property (out_load && !fir_clr
    |-> dec_seen_q == 12'(dec_last))
    else $error("decimation count wrong");
  byte_commit_a: assert property (fir_clr
    |=> fir_q == {$past(fr_data), $past(stage_lo_q)})
    else $error("register not built from staged low byte");
  read_reply_a: assert property (frame_valid && !fr_wr
    |=> tx_word_q == $past(reg_read(fr_addr)) ##1 $stable(tx_word_q))
    else $error("read reply not loaded");
  same_sample_a: assert property ($changed(out_q)
    |-> $past(out_load) && $changed(count_q))
    else $error("outputs changed apart from a load");
  scaled_tag_a: assert property (out_load && mode == MODE_SCALED
    |=> tag_q == $past(ts_q))
    else $error("time stamp not loaded in scaled mode");
endmodule // imu_core

// ### test/spi_master_model.sv
`timescale 1ns/1ps
module spi_master_model (
  output logic sclk,
  output logic cs_n,
  output logic mosi,
  input wire logic miso,
  input wire logic miso_oe
);
  localparam int HALF_NS = 16;
  localparam int GAP_NS = 600;
  // ----------------------------------------
  // idle levels
  // ----------------------------------------
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    mosi = 1'b0;
  end
  // ----------------------------------------
  // one framed transfer, full duplex
  // ----------------------------------------
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    #3 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      #HALF_NS sclk = 1'b0;
      mosi = tx[i];
      #HALF_NS sclk = 1'b1;
      rx[i] = (miso_oe === 1'b1) ? miso : 1'bx;
    end
    #HALF_NS cs_n = 1'b1;
    mosi = ~mosi;
    #GAP_NS;
  endtask
endmodule // spi_master_model

// ### test/imu_core_tb.sv
`timescale 1ns/1ps
module imu_core_tb;
  import imu_core_pkg::*;
  localparam int TP = 400;
  logic clk, rst, sclk, cs_n, mosi, miso, miso_oe, sync_in, rdy, rdy_q;
  sample_type raw;
  int fails, num_checks, rises, n, mid, r0;
  logic [15:0] v, c0, c1;
  logic [6:0] outs [6] = '{ADDR_GYRO_X, ADDR_GYRO_Y, ADDR_GYRO_Z,
                           ADDR_ACC_X, ADDR_ACC_Y, ADDR_ACC_Z};

  imu_core #(.TICK_PERIOD(TP)) i_imu_core (.clk(clk), .rst(rst),
    .sclk(sclk), .cs_n(cs_n), .mosi(mosi), .miso(miso),
    .miso_oe(miso_oe), .sync_in(sync_in), .raw_sample(raw),
    .sample_ready_output(rdy));
  spi_master_model i_spi_master_model (.sclk(sclk), .cs_n(cs_n),
    .mosi(mosi), .miso(miso), .miso_oe(miso_oe));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(negedge clk) begin
    rdy_q <= rdy;
    if (rdy === 1'b1 && rdy_q === 1'b0) rises++;
  end
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic rd(input logic [6:0] a, output logic [15:0] val);
    logic [15:0] dummy;
    i_spi_master_model.xfer({1'b0, a, 8'h00}, dummy);
    i_spi_master_model.xfer(16'h0000, val);
  endtask
  task automatic rdc(input logic [6:0] a, input logic [15:0] e, string w);
    logic [15:0] val;
    rd(a, val);
    check(val, e, w);
  endtask
  task automatic wr(input logic [6:0] a, input logic [15:0] val);
    logic [15:0] dummy;
    i_spi_master_model.xfer({1'b1, a, val[7:0]}, dummy);
    i_spi_master_model.xfer({1'b1, a | 7'h01, val[15:8]}, dummy);
  endtask
  task automatic wait_rise(output int cyc);
    cyc = 0;
    while (rdy === 1'b1 && cyc < 20000) begin
      @(negedge clk);
      cyc++;
    end
    while (rdy !== 1'b1 && cyc < 20000) begin
      @(negedge clk);
      cyc++;
    end
  endtask
  task automatic set_raw(input logic [15:0] g, input logic [15:0] a);
    @(posedge clk);
    raw <= '{gyro: '{g, g, g}, accel: '{a, a, a}};
  endtask
  task automatic sync_strobes(input int cnt);
    repeat (cnt) begin
      @(posedge clk);
      sync_in <= 1'b1;
      repeat (20) @(posedge clk);
      sync_in <= 1'b0;
      repeat (179) @(posedge clk);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ----------------------------------------
  // watchdog
  // ----------------------------------------
  initial begin
    #(25 * 90000);
    fails++;
    $display("BAD %0t watchdog expired", $time);
    test_done();
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    rst = 1'b1;
    sync_in = 1'b0;
    raw = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    check({15'h0000, miso_oe}, 16'h0000, "oe idle");
    rdc(ADDR_MISC, MISC_RST, "misc reset");
    rdc(ADDR_FIR | 7'h01, FIR_RST, "fir reset high byte");
    rdc(ADDR_DEC, DEC_RST, "dec reset");
    rdc(7'h7E, 16'h0000, "unmapped");
    wr(ADDR_DEC, 16'h0203);
    rdc(ADDR_DEC | 7'h01, 16'h0203, "dec write");
    wr(ADDR_DEC, 16'h0000);
    wait_rise(n);
    wait_rise(n);
    check(16'(n), 16'(TP), "rate");
    wr(ADDR_DEC, 16'h0003);
    wait_rise(n);
    wait_rise(n);
    check(16'(n), 16'(TP * 4), "decimation");
    wr(ADDR_DEC, 16'h0000);
    set_raw(16'h2000, 16'h4000);
    wr(ADDR_MISC, 16'h0001);
    repeat (3) wait_rise(n);
    for (int i = 0; i < 6; i++) begin
      rdc(outs[i], (i < 3) ? 16'h2000 : 16'h4000, "plain cal");
    end
    @(posedge clk);
    raw <= '{gyro: '{16'h3000, 16'h2000, 16'h1000}, accel: raw.accel};
    repeat (3) wait_rise(n);
    rdc(ADDR_GYRO_X, 16'h1000, "x axis kept");
    rdc(ADDR_GYRO_Z, 16'h3000, "z axis kept");
    set_raw(16'h2000, 16'h4000);
    wr(ADDR_MISC, 16'h0081);
    repeat (3) wait_rise(n);
    rdc(ADDR_GYRO_Y, 16'h2010, "linear g term");
    rdc(ADDR_ACC_Y, 16'h4000, "accel without term");
    wr(ADDR_MISC, 16'h0041);
    repeat (3) wait_rise(n);
    rdc(ADDR_GYRO_X, 16'h2000, "gyro without term");
    rdc(ADDR_ACC_X, 16'h4004, "percussion term");
    wr(ADDR_MISC, 16'h0001);
    wr(ADDR_FIR, 16'h0001);
    rdc(ADDR_FIR, 16'h0001, "fir write");
    set_raw(16'h1000, 16'h4000);
    repeat (5) wait_rise(n);
    rdc(ADDR_GYRO_Z, 16'h1000, "fir settled");
    set_raw(16'h2000, 16'h4000);
    mid = 0;
    repeat (5) begin
      wait_rise(n);
      rd(ADDR_GYRO_Z, v);
      if (v > 16'h1000 && v < 16'h2000) mid++;
    end
    check(16'(mid), 16'h0002, "fir taps");
    check(v, 16'h2000, "fir final");
    for (int m = 1; m < 4; m++) begin
      wr(ADDR_MISC, 16'(m << MISC_MODE_LSB) | 16'h0001);
      repeat (50) @(posedge clk);
      r0 = rises;
      fork
        sync_strobes(6);
      join_none
      wait_rise(n);
      rd(ADDR_COUNT, c0);
      wait_rise(n);
      rd(ADDR_COUNT, c1);
      wait fork;
      repeat (50) @(posedge clk);
      check(16'(rises - r0), 16'h0006, "sync loads");
      check(c1 - c0, (m == 2) ? 16'h00C8 : 16'h0001, "count");
    end
    wr(ADDR_MISC, 16'h00C0);
    mid = 0;
    while (rdy !== 1'b0 && mid < 2 * TP) begin
      @(negedge clk);
      mid++;
    end
    mid = 0;
    while (rdy === 1'b0 && mid < TP) begin
      @(negedge clk);
      mid++;
    end
    check(16'(mid), 16'(DR_HOLD_CYC), "ready low time");
    test_done();
  end
endmodule // imu_core_tb
